// ---- cseq_params.svh ----
// Constants for the core store address and drive sequencer.
`ifndef CSEQ_PARAMS_SVH
`define CSEQ_PARAMS_SVH
`define CSEQ_CLK_PERIOD_NS 8
`define CSEQ_READ_STEP_NS 1000
`define CSEQ_WRITE_STEP_NS 1000
`define CSEQ_INH_LEAD_NS 200
`define CSEQ_DISTURB_NS 2000
`define CSEQ_CYCLES_MIN(ns) (((ns) + `CSEQ_CLK_PERIOD_NS - 1) / `CSEQ_CLK_PERIOD_NS)
`define CSEQ_OFF_CTRL 12'h000
`define CSEQ_OFF_STATUS 12'h004
`define CSEQ_OFF_ADDR 12'h008
`define CSEQ_OFF_WDATA_LO 12'h00c
`define CSEQ_OFF_WDATA_HI 12'h010
`define CSEQ_OFF_RDATA_LO 12'h014
`define CSEQ_OFF_RDATA_HI 12'h018
`define CSEQ_CTRL_SEQ_LSB 0
`define CSEQ_CTRL_START_BIT 8
`define CSEQ_STAT_BUSY_BIT 0
`define CSEQ_STAT_ADDR_LSB 16
`define CSEQ_RST_STORAGE_ADDR 16'h0000
`define CSEQ_RST_WORD 36'h0_0000_0000
`define CSEQ_LO_FIRST 0
`define CSEQ_LO_LAST 14
`define CSEQ_MID_FIRST 15
`define CSEQ_MID_LAST 29
`endif

// ---- cseq_pkg.sv ----
// Types shared by the core store address and drive sequencer.
package cseq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CLEAR = 3'b001,
    ST_READ = 3'b010,
    ST_LEAD = 3'b011,
    ST_WRITE = 3'b100,
    ST_DISTURB = 3'b101
  } cseq_state_t;
  typedef enum logic [1:0] {
    SEQ_READ = 2'b00,
    SEQ_WRITE = 2'b01,
    SEQ_WRITE_LO = 2'b10,
    SEQ_WRITE_MID = 2'b11
  } cseq_kind_t;
endpackage

// ---- cseq_core_drive.sv ----
// Address latch, line decoders, step sequencer and digit controls for a 1024 x 36 core store.
`include "cseq_params.svh"
`timescale 1ns/1ps
module cseq_core_drive #(
  parameter int READ_CYC = `CSEQ_CYCLES_MIN(`CSEQ_READ_STEP_NS),
  parameter int WRITE_CYC = `CSEQ_CYCLES_MIN(`CSEQ_WRITE_STEP_NS),
  parameter int LEAD_CYC = `CSEQ_CYCLES_MIN(`CSEQ_INH_LEAD_NS),
  parameter int DIST_CYC = `CSEQ_CYCLES_MIN(`CSEQ_DISTURB_NS)
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [35:0] sense,
  output logic [31:0] x_read_drive,
  output logic [31:0] x_write_drive,
  output logic [31:0] y_read_drive,
  output logic [31:0] y_write_drive,
  output logic [35:0] inhibit_drive,
  output logic busy
);

  function automatic logic [3:0] dec2(input logic [1:0] a, input logic en);
    dec2 = en ? (4'h1 << a) : 4'h0;
  endfunction

  function automatic logic [7:0] dec3(input logic [2:0] a, input logic en);
    dec3 = en ? (8'h01 << a) : 8'h00;
  endfunction

  // A driver fires only where its group enable and its select pulse coincide.
  function automatic logic [31:0] drive_lines(input logic [3:0] grp, input logic [7:0] sel);
    logic [31:0] l;
    l = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      l[i] = grp[i / 8] & sel[i % 8];
    end
    drive_lines = l;
  endfunction

  function automatic logic [35:0] write_mask(input cseq_pkg::cseq_kind_t k);
    logic [35:0] m;
    m = 36'h0_0000_0000;
    for (int i = 0; i < 36; i++) begin
      unique case (k)
        cseq_pkg::SEQ_READ: m[i] = 1'b0;
        cseq_pkg::SEQ_WRITE: m[i] = 1'b1;
        cseq_pkg::SEQ_WRITE_LO: m[i] = (i >= `CSEQ_LO_FIRST) && (i <= `CSEQ_LO_LAST);
        cseq_pkg::SEQ_WRITE_MID: m[i] = (i >= `CSEQ_MID_FIRST) && (i <= `CSEQ_MID_LAST);
      endcase
    end
    write_mask = m;
  endfunction

  cseq_pkg::cseq_state_t state_r;
  cseq_pkg::cseq_kind_t kind_r;
  logic [11:0] cnt_r;
  logic [15:0] storage_address_reg_r;
  logic [9:0] core_address_reg_r;
  logic [35:0] wdata_r;
  logic [35:0] rdata_r;
  logic [35:0] input_restore_flop_r;
  logic [35:0] sense_s1_r;
  logic [35:0] sense_s2_r;
  logic [35:0] sense_s3_r;
  logic [35:0] sense_q_r;
  logic wr_pend_r;
  logic [11:0] wr_addr_r;
  logic start_req;
  logic accept;
  logic step_end;
  logic read_enable;
  logic read_pulse;
  logic write_enable;
  logic write_pulse;
  logic inh_dist_enable;
  logic disturb_enable;
  logic [35:0] wmask;
  logic [3:0] x_group_enable;
  logic [7:0] x_low_select_pulse;
  logic [3:0] x_group_wr;
  logic [7:0] x_low_wr;
  logic [3:0] y_group_enable;
  logic [7:0] y_low_select_pulse;
  logic [3:0] y_group_wr;
  logic [7:0] y_low_wr;

  // Zero wait states; a low clock enable stalls the bus with the rest of the block.
  assign hreadyout = clk_en;
  assign hresp = 1'b0;
  assign busy = (state_r != cseq_pkg::ST_IDLE);
  assign start_req = wr_pend_r && (wr_addr_r == `CSEQ_OFF_CTRL) && hwdata[`CSEQ_CTRL_START_BIT];
  assign accept = start_req && !busy;
  assign step_end = (cnt_r == 12'h000);
  assign wmask = write_mask(kind_r);

  // Access control timing signals gating the decoders and the inhibit drivers.
  assign read_enable = (state_r == cseq_pkg::ST_READ);
  assign read_pulse = read_enable;
  assign write_enable = (state_r == cseq_pkg::ST_WRITE);
  assign write_pulse = write_enable;
  assign inh_dist_enable = (state_r == cseq_pkg::ST_LEAD) || (state_r == cseq_pkg::ST_WRITE) ||
                           (state_r == cseq_pkg::ST_DISTURB);
  assign disturb_enable = (state_r == cseq_pkg::ST_DISTURB);

  assign x_group_enable = dec2(core_address_reg_r[4:3], read_enable);
  assign x_low_select_pulse = dec3(core_address_reg_r[2:0], read_pulse);
  assign x_group_wr = dec2(core_address_reg_r[4:3], write_enable);
  assign x_low_wr = dec3(core_address_reg_r[2:0], write_pulse);
  assign y_group_enable = dec2(core_address_reg_r[9:8], read_enable);
  assign y_low_select_pulse = dec3(core_address_reg_r[7:5], read_pulse);
  assign y_group_wr = dec2(core_address_reg_r[9:8], write_enable);
  assign y_low_wr = dec3(core_address_reg_r[7:5], write_pulse);

  // Sense inputs arrive from the planes; a change counts once stages two and three agree.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sense_s1_r <= 36'h0_0000_0000;
      sense_s2_r <= 36'h0_0000_0000;
      sense_s3_r <= 36'h0_0000_0000;
      sense_q_r <= 36'h0_0000_0000;
    end else if (clk_en) begin
      sense_s1_r <= sense;
      sense_s2_r <= sense_s1_r;
      sense_s3_r <= sense_s2_r;
      sense_q_r <= (sense_s2_r & sense_s3_r) | (sense_q_r & (sense_s2_r | sense_s3_r));
    end
  end

  // Bus address phase; writes complete in the data phase, read data is loaded for it.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      hrdata <= 32'h0000_0000;
    end else if (clk_en) begin
      wr_pend_r <= hsel && htrans[1] && hwrite && hready && (hsize == 3'b010) && (haddr[31:12] == 20'h0_0000);
      wr_addr_r <= haddr[11:0];
      if (hsel && htrans[1] && !hwrite && hready) begin
        hrdata <= 32'h0000_0000;
        if (haddr[31:12] == 20'h0_0000) begin
          unique case (haddr[11:0])
            `CSEQ_OFF_CTRL: hrdata[`CSEQ_CTRL_SEQ_LSB +: 2] <= kind_r;
            `CSEQ_OFF_STATUS: begin
              hrdata[`CSEQ_STAT_BUSY_BIT] <= busy;
              hrdata[`CSEQ_STAT_ADDR_LSB +: 10] <= core_address_reg_r;
            end
            `CSEQ_OFF_ADDR: hrdata[15:0] <= storage_address_reg_r;
            `CSEQ_OFF_WDATA_LO: hrdata <= wdata_r[31:0];
            `CSEQ_OFF_WDATA_HI: hrdata[3:0] <= wdata_r[35:32];
            `CSEQ_OFF_RDATA_LO: hrdata <= rdata_r[31:0];
            `CSEQ_OFF_RDATA_HI: hrdata[3:0] <= rdata_r[35:32];
            default: hrdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      storage_address_reg_r <= `CSEQ_RST_STORAGE_ADDR;
      wdata_r <= `CSEQ_RST_WORD;
    end else if (clk_en && wr_pend_r) begin
      if (wr_addr_r == `CSEQ_OFF_ADDR) begin
        storage_address_reg_r <= hwdata[15:0];
      end
      if (wr_addr_r == `CSEQ_OFF_WDATA_LO) begin
        wdata_r[31:0] <= hwdata;
      end
      if (wr_addr_r == `CSEQ_OFF_WDATA_HI) begin
        wdata_r[35:32] <= hwdata[3:0];
      end
    end
  end

  // Step sequencer: clear flops, read, inhibit lead, write, disturb.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= cseq_pkg::ST_IDLE;
      cnt_r <= 12'h000;
    end else if (clk_en) begin
      unique case (state_r)
        cseq_pkg::ST_IDLE: begin
          if (accept) begin
            state_r <= cseq_pkg::ST_CLEAR;
          end
        end
        cseq_pkg::ST_CLEAR: begin
          state_r <= cseq_pkg::ST_READ;
          cnt_r <= 12'(READ_CYC - 1);
        end
        cseq_pkg::ST_READ: begin
          if (step_end) begin
            state_r <= cseq_pkg::ST_LEAD;
            cnt_r <= 12'(LEAD_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 12'h001;
          end
        end
        cseq_pkg::ST_LEAD: begin
          if (step_end) begin
            state_r <= cseq_pkg::ST_WRITE;
            cnt_r <= 12'(WRITE_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 12'h001;
          end
        end
        cseq_pkg::ST_WRITE: begin
          if (step_end) begin
            state_r <= cseq_pkg::ST_DISTURB;
            cnt_r <= 12'(DIST_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 12'h001;
          end
        end
        cseq_pkg::ST_DISTURB: begin
          if (step_end) begin
            state_r <= cseq_pkg::ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 12'h001;
          end
        end
        default: begin
          state_r <= cseq_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      kind_r <= cseq_pkg::SEQ_READ;
      core_address_reg_r <= 10'h000;
    end else if (clk_en && accept) begin
      kind_r <= cseq_pkg::cseq_kind_t'(hwdata[`CSEQ_CTRL_SEQ_LSB +: 2]);
      core_address_reg_r <= storage_address_reg_r[9:0];
    end
  end

  // Digit controls: plane n exchanges data with word bit n only.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      input_restore_flop_r <= 36'h0_0000_0000;
      rdata_r <= `CSEQ_RST_WORD;
    end else if (clk_en) begin
      if (accept && (hwdata[`CSEQ_CTRL_SEQ_LSB +: 2] == cseq_pkg::SEQ_READ)) begin
        rdata_r <= `CSEQ_RST_WORD;
      end
      if (state_r == cseq_pkg::ST_CLEAR) begin
        input_restore_flop_r <= 36'h0_0000_0000;
      end else if (state_r == cseq_pkg::ST_READ) begin
        input_restore_flop_r <= input_restore_flop_r | (sense_q_r & ~wmask) |
                                (step_end ? (wdata_r & wmask) : 36'h0_0000_0000);
        if (kind_r == cseq_pkg::SEQ_READ) begin
          rdata_r <= rdata_r | sense_q_r;
        end
      end
    end
  end

  // Drive outputs are registered from the decoded step signals.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      x_read_drive <= 32'h0000_0000;
      x_write_drive <= 32'h0000_0000;
      y_read_drive <= 32'h0000_0000;
      y_write_drive <= 32'h0000_0000;
      inhibit_drive <= 36'h0_0000_0000;
    end else if (clk_en) begin
      x_read_drive <= drive_lines(x_group_enable, x_low_select_pulse);
      x_write_drive <= drive_lines(x_group_wr, x_low_wr);
      y_read_drive <= drive_lines(y_group_enable, y_low_select_pulse);
      y_write_drive <= drive_lines(y_group_wr, y_low_wr);
      inhibit_drive <= (inh_dist_enable ? ~input_restore_flop_r : 36'h0_0000_0000) |
                       (disturb_enable ? 36'hf_ffff_ffff : 36'h0_0000_0000);
    end
  end

  a_addr_latch: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && accept |=> core_address_reg_r == $past(storage_address_reg_r[9:0]))
    else $error("core address not copied from storage address");

  a_read_onehot: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && state_r == cseq_pkg::ST_READ |=> $onehot(x_read_drive) && $onehot(y_read_drive) &&
    x_write_drive == 32'h0000_0000)
    else $error("read step does not drive exactly one X and one Y line");

  a_write_line: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && state_r == cseq_pkg::ST_WRITE |=> x_write_drive == (32'h0000_0001 << core_address_reg_r[4:0]) &&
    y_write_drive == (32'h0000_0001 << core_address_reg_r[9:5]) && x_read_drive == 32'h0000_0000)
    else $error("write step drives the wrong line");

  a_inhibit_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && (state_r == cseq_pkg::ST_LEAD || state_r == cseq_pkg::ST_WRITE) |=>
    inhibit_drive == ~input_restore_flop_r)
    else $error("inhibit does not follow zero digit flops");

  a_disturb_all: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && state_r == cseq_pkg::ST_DISTURB |=> inhibit_drive == 36'hf_ffff_ffff &&
    x_write_drive == 32'h0000_0000)
    else $error("disturb not applied to every plane");

  a_disturb_len: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && state_r == cseq_pkg::ST_WRITE && step_end |=>
    state_r == cseq_pkg::ST_DISTURB && cnt_r == 12'(DIST_CYC - 1))
    else $error("disturb tail has the wrong length");

  a_read_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && state_r == cseq_pkg::ST_READ |=> inhibit_drive == 36'h0_0000_0000)
    else $error("inhibit active during read step");

  a_flops_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && state_r == cseq_pkg::ST_CLEAR |=> input_restore_flop_r == 36'h0_0000_0000)
    else $error("digit flops not cleared at sequence start");

  a_busy_refuse: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && busy && start_req |=> $stable(core_address_reg_r) && $stable(kind_r))
    else $error("initiate accepted while busy");

  a_write_no_sense: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en && state_r == cseq_pkg::ST_READ && kind_r != cseq_pkg::SEQ_READ |=> $stable(rdata_r))
    else $error("sense passed to word register in a write sequence");

endmodule

// ---- cseq_core_store_model.sv ----
// Behavioural model of the core planes and their sense amplifiers.
`timescale 1ns/1ps
module cseq_core_store_model (
  input wire logic clk_sys,
  input wire logic [31:0] x_read_drive,
  input wire logic [31:0] x_write_drive,
  input wire logic [31:0] y_read_drive,
  input wire logic [31:0] y_write_drive,
  input wire logic [35:0] inhibit_drive,
  output logic [35:0] sense
);
  logic [35:0] mem [0:1023];
  logic [9:0] rd_idx;
  logic [9:0] wr_idx;
  function automatic logic [4:0] cseq_enc(input logic [31:0] v);
    cseq_enc = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        cseq_enc = 5'(i);
      end
    end
  endfunction
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 36'h0_0000_0000;
    end
  end
  assign rd_idx = {cseq_enc(y_read_drive), cseq_enc(x_read_drive)};
  assign wr_idx = {cseq_enc(y_write_drive), cseq_enc(x_write_drive)};
  // A cell answers only where exactly one X line and one Y line coincide.
  assign sense = ($onehot(x_read_drive) && $onehot(y_read_drive)) ? mem[rd_idx] : 36'h0_0000_0000;
  // Uninhibited planes take a one from the write drive, inhibited planes keep zero.
  always @(posedge clk_sys) begin
    if ($onehot(x_write_drive) && $onehot(y_write_drive)) begin
      mem[wr_idx] <= ~inhibit_drive;
    end
  end
endmodule

// ---- cseq_core_drive_tb_top.sv ----
// Self-checking testbench for the core store sequencer.
`include "cseq_params.svh"
`timescale 1ns/1ps
module cseq_core_drive_tb_top;
  localparam int RC = 8;
  localparam int WC = 4;
  localparam int LC = 2;
  localparam int DC = 6;
  logic clk_sys, reset_n, clk_en, hsel, hwrite, hreadyout, hresp, busy;
  logic [31:0] haddr, hwdata, hrdata, rd, xr_or, yw_or, xw_or, yr_or;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [35:0] sense, inhibit_drive, m1, m2;
  logic [31:0] x_read_drive, x_write_drive, y_read_drive, y_write_drive;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_rd, n_wr, n_busy, n_i0, n_i1, n_o0, n_o1;
  cseq_core_drive #(.READ_CYC(RC), .WRITE_CYC(WC), .LEAD_CYC(LC), .DIST_CYC(DC)) u_cseq_core_drive (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sense(sense), .x_read_drive(x_read_drive),
    .x_write_drive(x_write_drive), .y_read_drive(y_read_drive), .y_write_drive(y_write_drive),
    .inhibit_drive(inhibit_drive), .busy(busy));
  cseq_core_store_model u_cseq_core_store_model (
    .clk_sys(clk_sys), .x_read_drive(x_read_drive), .x_write_drive(x_write_drive),
    .y_read_drive(y_read_drive), .y_write_drive(y_write_drive), .inhibit_drive(inhibit_drive),
    .sense(sense));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Counts drive cycles of the current sequence for planes 0 and 1.
  always @(posedge clk_sys) begin
    if (reset_n) begin
      n_rd += int'(|x_read_drive && |y_read_drive);
      n_wr += int'(|x_write_drive && |y_write_drive);
      n_busy += int'(busy === 1'b1);
      n_i0 += int'(inhibit_drive[0] === 1'b1);
      n_i1 += int'(inhibit_drive[1] === 1'b1);
      n_o0 += int'(inhibit_drive[0] && |x_write_drive);
      n_o1 += int'(inhibit_drive[1] && |x_write_drive);
      xr_or = xr_or | x_read_drive;
      yw_or = yw_or | y_write_drive;
      xw_or = xw_or | x_write_drive;
      yr_or = yr_or | y_read_drive;
    end
  end
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {20'h00000, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check32(rd, exp);
    check32({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask
  task automatic wr_word(input logic [35:0] d);
    bus(1'b1, `CSEQ_OFF_WDATA_LO, d[31:0]);
    bus(1'b1, `CSEQ_OFF_WDATA_HI, {28'h0000000, d[35:32]});
  endtask
  task automatic rd_word(input logic [35:0] d);
    rd_chk(`CSEQ_OFF_RDATA_LO, d[31:0]);
    rd_chk(`CSEQ_OFF_RDATA_HI, {28'h0000000, d[35:32]});
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
  endtask
  // Runs one sequence; fin is the word the addressed location must hold afterwards.
  task automatic run_seq(input logic [1:0] kind, input logic [9:0] a, input logic [35:0] fin);
    bus(1'b1, `CSEQ_OFF_ADDR, {22'h000000, a});
    {n_rd, n_wr, n_busy, n_i0, n_i1, n_o0, n_o1} = '0;
    xr_or = 32'h0000_0000;
    yw_or = 32'h0000_0000;
    xw_or = 32'h0000_0000;
    yr_or = 32'h0000_0000;
    bus(1'b1, `CSEQ_OFF_CTRL, {23'h000000, 1'b1, 6'h00, kind});
    rd_chk(`CSEQ_OFF_STATUS, {6'h00, a, 15'h0000, 1'b1});
    wait_idle();
    check32(32'(n_busy), 32'(1 + RC + LC + WC + DC));
    check32(32'(n_rd), 32'(RC));
    check32(32'(n_wr), 32'(WC));
    check32(xr_or, 32'h0000_0001 << a[4:0]);
    check32(yw_or, 32'h0000_0001 << a[9:5]);
    check32(xw_or, 32'h0000_0001 << a[4:0]);
    check32(yr_or, 32'h0000_0001 << a[9:5]);
    check32(32'(n_i0), 32'(fin[0] ? DC : LC + WC + DC));
    check32(32'(n_i1), 32'(fin[1] ? DC : LC + WC + DC));
    check32(32'(n_o0), 32'(fin[0] ? 0 : WC));
    check32(32'(n_o1), 32'(fin[1] ? 0 : WC));
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    finish_test();
  end
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    hsize = 3'b010;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd_chk(`CSEQ_OFF_STATUS, 32'h0000_0000);
    rd_chk(`CSEQ_OFF_ADDR, 32'h0000_0000);
    rd_chk(12'h01c, 32'h0000_0000);
    hsize <= 3'b000;
    bus(1'b1, `CSEQ_OFF_ADDR, 32'h0000_03ff);
    hsize <= 3'b010;
    rd_chk(`CSEQ_OFF_ADDR, 32'h0000_0000);
    wr_word(36'h9_a5a5_5a59);
    run_seq(cseq_pkg::SEQ_WRITE, 10'h2cd, 36'h9_a5a5_5a59);
    run_seq(cseq_pkg::SEQ_READ, 10'h2cd, 36'h9_a5a5_5a59);
    rd_word(36'h9_a5a5_5a59);
    m1 = 36'h9_a5a5_5a59;
    m1[14:0] = 15'h7ffe;
    wr_word(36'h0_0000_7ffe);
    run_seq(cseq_pkg::SEQ_WRITE_LO, 10'h2cd, m1);
    rd_word(36'h9_a5a5_5a59);
    run_seq(cseq_pkg::SEQ_READ, 10'h2cd, m1);
    rd_word(m1);
    m2 = {m1[35:30], 15'h7fff, m1[14:0]};
    wr_word(36'h0_3fff_8000);
    run_seq(cseq_pkg::SEQ_WRITE_MID, 10'h2cd, m2);
    run_seq(cseq_pkg::SEQ_READ, 10'h2cd, m2);
    rd_word(m2);
    run_seq(cseq_pkg::SEQ_READ, 10'h01f, 36'h0_0000_0000);
    rd_word(36'h0_0000_0000);
    bus(1'b1, `CSEQ_OFF_ADDR, 32'h0000_03e0);
    n_busy = 0;
    bus(1'b1, `CSEQ_OFF_CTRL, 32'h0000_0100);
    bus(1'b1, `CSEQ_OFF_CTRL, 32'h0000_0101);
    bus(1'b1, `CSEQ_OFF_ADDR, 32'h0000_0000);
    rd_chk(`CSEQ_OFF_STATUS, {6'h00, 10'h3e0, 15'h0000, 1'b1});
    rd_chk(`CSEQ_OFF_CTRL, 32'h0000_0000);
    // A low clock enable freezes the sequence and stalls the bus.
    clk_en <= 1'b0;
    repeat (5) @(posedge clk_sys);
    check32({31'h0000_0000, hreadyout}, 32'h0000_0000);
    check32({31'h0000_0000, busy}, 32'h0000_0001);
    clk_en <= 1'b1;
    wait_idle();
    check32(32'(n_busy), 32'(1 + RC + LC + WC + DC + 5));
    rd_chk(`CSEQ_OFF_STATUS, {6'h00, 10'h3e0, 16'h0000});
    finish_test();
  end
endmodule
